// ==== hdl/cssp_top.sv ====
// How it works
// - one transfer moves exactly eight data bits
// - pin function bits 3,2,1 select mode
// - data register shifts out and in
// - output pin undefined until data or idle
// - start clears counter; counter counts rising edges
// - leaving transfer clears counter, sets flag
// - reset gives start-wait; clock edges ignored
// - start in start-wait enters clock-wait
// - first edge in clock-wait starts transfer
// - continuous mode with internal clock enters clock output state
// - clock select write returns to start-wait
// - start during transfer returns to clock-wait
// - after eight clocks: external clock-wait, internal stop
// - continuous state only drives serial clock
// - idle output level from idle control bit
// - eighth noisy pulse ends transfer, flag set
// - dummy clock select write sets flag again
// - no flag if stopped in first low phase
// - lsb first; out on fall, in on rise
// - clock select acts two instructions later
// - prescaler, system clock or external selection
//
// Added by the designer: the address-and-strobe port.
module cssp_top #(
   parameter int PRESCALE_W = 14  // prescaler width, 2048*4 needs 13 bits
) (
   input  wire logic       mclk,        // system clock
   input  wire logic       rst,         // synchronous reset
   input  wire logic [6:0] reg_addr,    // register address
   input  wire logic [3:0] reg_wdata,   // write data nibble
   input  wire logic       reg_wr,      // write strobe
   input  wire logic       reg_rd,      // read strobe
   output logic      [3:0] reg_rdata,   // read data, cycle after strobe
   input  wire logic       start_xfer,  // start instruction pulse
   input  wire logic       flag_clr,    // clear request flag pulse
   output logic            req_flag,    // serial request flag
   input  wire logic       sck_in,      // serial clock pin input
   output logic            sck_out,     // serial clock pin output level
   output logic            sck_oe_n,    // low while clock pin driven
   input  wire logic       sdi,         // serial data in
   output logic            sdo,         // serial data out
   output logic            sdo_oe_n     // low while data pin driven
);
   initial begin
      if (PRESCALE_W < 13 || PRESCALE_W > 24)
         $error("PRESCALE_W out of range");
   end

   logic [3:0]  pin_func_q, clk_sel_q, clk_sel_act_q;
   logic [1:0]  idle_lvl_q;
   logic [7:0]  shreg_q;
   logic [2:0]  cnt_q;
   logic [1:0]  csdly_q;
   logic        flag_q, sdo_q, sck_gen_q, sck_s1_q, sck_s2_q, sck_s3_q;
   logic        first_low_q, cs_pend_q;
   logic [PRESCALE_W-1:0] pre_q;
   logic [3:0]  rdata_q;
   cssp_pkg::cssp_state_t state_q, state_d;

   wire wr_pin  = reg_wr && reg_addr == cssp_pkg::OFF_PIN_FUNC;
   wire wr_cs   = reg_wr && reg_addr == cssp_pkg::OFF_CLK_SEL;
   wire wr_idle = reg_wr && reg_addr == cssp_pkg::OFF_IDLE_LVL;
   wire wr_lo   = reg_wr && reg_addr == cssp_pkg::OFF_DATA_LO;
   wire wr_hi   = reg_wr && reg_addr == cssp_pkg::OFF_DATA_HI;

   // mode decode from pin function bits
   wire pf_en    = pin_func_q[cssp_pkg::PF_ENA_BIT];
   wire mode_cont = pf_en && !pin_func_q[cssp_pkg::PF_XFER_BIT];
   wire mode_rx  = pf_en && pin_func_q[cssp_pkg::PF_XFER_BIT]
                   && !pin_func_q[cssp_pkg::PF_DIR_BIT];
   wire mode_tx  = pf_en && pin_func_q[cssp_pkg::PF_XFER_BIT]
                   && pin_func_q[cssp_pkg::PF_DIR_BIT];
   wire ext_clk  = clk_sel_act_q[2:0] == cssp_pkg::CSEL_EXT;

   // internal clock period select: tap of the prescaler
   function automatic int tap_of(input logic [3:0] sel);
      int t;
      t = 0;
      case (sel[2:0])
         3'h0: t = 11;
         3'h1: t = 9;
         3'h2: t = 7;
         3'h3: t = 5;
         3'h4: t = 3;
         3'h5: t = 1;
         default: t = 0;
      endcase
      return t + (sel[cssp_pkg::CS_DIV4_BIT] ? 1 : 0);
   endfunction

   // one generated edge every half period; system clock mode toggles
   // every cycle for div2, every other cycle for div4
   logic [PRESCALE_W-1:0] half_mask;
   always_comb begin
      half_mask = '0;
      if (clk_sel_act_q[2:0] == cssp_pkg::CSEL_SYSCLK)
         half_mask = clk_sel_act_q[3] ? PRESCALE_W'(1) : '0;
      else
         half_mask = PRESCALE_W'((1 << tap_of(clk_sel_act_q)) - 1);
   end
   wire gen_run  = !ext_clk && (state_q == cssp_pkg::ST_CLK_WAIT
                   || state_q == cssp_pkg::ST_XFER
                   || state_q == cssp_pkg::ST_CONT) && !cs_pend_q;
   wire gen_tick = gen_run && ((pre_q & half_mask) == half_mask);

   // edges of the serial clock seen by the shifter
   wire ext_fall = sck_s3_q && !sck_s2_q;
   wire ext_rise = !sck_s3_q && sck_s2_q;
   wire sck_fall = ext_clk ? ext_fall : gen_tick && sck_gen_q;
   wire sck_rise = ext_clk ? ext_rise : gen_tick && !sck_gen_q;
   wire sck_lvl  = ext_clk ? sck_s2_q : sck_gen_q;
   wire cnt_last = cnt_q == 3'(cssp_pkg::BITS_PER_XFER - 1);

   // leaving transfer: flag unless stopped in first low phase
   wire xfer_done = state_q == cssp_pkg::ST_XFER && sck_rise && cnt_last;
   wire xfer_abort = state_q == cssp_pkg::ST_XFER && (start_xfer || wr_cs);
   wire set_flag  = xfer_done || (xfer_abort && !first_low_q)
                    || (wr_cs && state_q == cssp_pkg::ST_START_WAIT
                        && !flag_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         cssp_pkg::ST_START_WAIT: begin
            if (start_xfer)
               state_d = cssp_pkg::ST_CLK_WAIT;
         end
         cssp_pkg::ST_CLK_WAIT: begin
            if (wr_cs)
               state_d = cssp_pkg::ST_START_WAIT;
            else if (sck_fall && mode_cont && !ext_clk)
               state_d = cssp_pkg::ST_CONT;
            else if (sck_fall && (mode_rx || mode_tx))
               state_d = cssp_pkg::ST_XFER;
         end
         cssp_pkg::ST_XFER: begin
            if (wr_cs)
               state_d = cssp_pkg::ST_START_WAIT;
            else if (start_xfer)
               state_d = cssp_pkg::ST_CLK_WAIT;
            else if (xfer_done)
               state_d = ext_clk ? cssp_pkg::ST_CLK_WAIT
                                 : cssp_pkg::ST_START_WAIT;
         end
         cssp_pkg::ST_CONT: begin
            if (wr_cs)
               state_d = cssp_pkg::ST_START_WAIT;
         end
         default: state_d = cssp_pkg::ST_START_WAIT;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= cssp_pkg::ST_START_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   // registers written by software
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_func_q <= cssp_pkg::RST_PIN_FUNC;
         clk_sel_q  <= cssp_pkg::RST_CLK_SEL;
         idle_lvl_q <= cssp_pkg::RST_IDLE_LVL;
      end else begin
         if (wr_pin)
            pin_func_q <= reg_wdata;
         if (wr_cs)
            clk_sel_q <= reg_wdata;
         if (wr_idle && state_q != cssp_pkg::ST_XFER)
            idle_lvl_q <= reg_wdata[1:0];
      end
   end

   // clock select takes effect after two instruction slots
   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_sel_act_q <= cssp_pkg::RST_CLK_SEL;
         csdly_q       <= 2'h0;
         cs_pend_q     <= 1'b0;
      end else if (wr_cs) begin
         csdly_q   <= 2'(cssp_pkg::CLK_SEL_DELAY);
         cs_pend_q <= 1'b1;
      end else if (cs_pend_q) begin
         if (csdly_q == 2'h1) begin
            clk_sel_act_q <= clk_sel_q;
            cs_pend_q     <= 1'b0;
         end
         csdly_q <= csdly_q - 2'h1;
      end
   end

   // prescaler and generated serial clock (idle high)
   always_ff @(posedge mclk) begin
      if (rst || !gen_run) begin
         pre_q     <= '0;
         sck_gen_q <= 1'b1;
      end else begin
         pre_q <= pre_q + PRESCALE_W'(1);
         if (gen_tick)
            sck_gen_q <= !sck_gen_q;
      end
   end

   // pin sampling: s1 feeds s2, s2 feeds s3
   always_ff @(posedge mclk) begin
      if (rst) begin
         sck_s1_q <= 1'b1;
         sck_s2_q <= 1'b1;
         sck_s3_q <= 1'b1;
      end else begin
         sck_s1_q <= sck_in;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
      end
   end

   // pulse counter and first-low tracking
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q       <= cssp_pkg::CNT_ZERO;
         first_low_q <= 1'b0;
      end else if (start_xfer || wr_cs || xfer_done) begin
         cnt_q       <= cssp_pkg::CNT_ZERO;
         first_low_q <= 1'b0;
      end else if (state_q == cssp_pkg::ST_XFER && sck_rise) begin
         cnt_q       <= cnt_q + 3'h1;
         first_low_q <= 1'b0;
      end else if (state_q == cssp_pkg::ST_CLK_WAIT && state_d ==
                   cssp_pkg::ST_XFER) begin
         first_low_q <= 1'b1;
      end
   end

   // request flag: hardware set wins over clear
   always_ff @(posedge mclk) begin
      if (rst)
         flag_q <= 1'b0;
      else if (set_flag)
         flag_q <= 1'b1;
      else if (flag_clr)
         flag_q <= 1'b0;
   end

   // shift register and data pin; lsb first
   wire in_xfer = state_q == cssp_pkg::ST_XFER || state_d == cssp_pkg::ST_XFER;
   always_ff @(posedge mclk) begin
      if (rst) begin
         shreg_q <= 8'h00;
         sdo_q   <= 1'b1;
      end else begin
         if (wr_lo)
            shreg_q[3:0] <= reg_wdata;
         else if (wr_hi)
            shreg_q[7:4] <= reg_wdata;
         else if (in_xfer && sck_rise && state_q == cssp_pkg::ST_XFER)
            shreg_q <= {(mode_rx ? sdi : shreg_q[0]),
                        shreg_q[7:1]};
         if (in_xfer && sck_fall && mode_tx)
            sdo_q <= shreg_q[0];
         else if (!in_xfer && (wr_idle || state_q == cssp_pkg::ST_START_WAIT))
            sdo_q <= wr_idle ? reg_wdata[cssp_pkg::IDLE_LVL_BIT]
                             : idle_lvl_q[cssp_pkg::IDLE_LVL_BIT];
      end
   end

   // read port
   wire [3:0] rd_mux =
      reg_addr == cssp_pkg::OFF_DATA_LO ? shreg_q[3:0] :
      reg_addr == cssp_pkg::OFF_DATA_HI ? shreg_q[7:4] :
      reg_addr == cssp_pkg::OFF_STATUS  ?
         {state_q, sck_lvl, flag_q} : 4'h0;
   always_ff @(posedge mclk) begin
      if (rst)
         rdata_q <= 4'h0;
      else
         rdata_q <= reg_rd ? rd_mux : 4'h0;
   end

   assign reg_rdata = rdata_q;
   assign req_flag  = flag_q;
   assign sck_out   = sck_gen_q;
   assign sck_oe_n  = !(pf_en && !ext_clk);
   assign sdo       = sdo_q;
   assign sdo_oe_n  = !(pf_en && !mode_rx && !mode_cont);
endmodule

// ==== hdl/cssp_pkg.sv ====
package cssp_pkg;
   // register offsets as printed (7-bit register space)
   localparam logic [6:0] OFF_PIN_FUNC   = 7'h0B;
   localparam logic [6:0] OFF_CLK_SEL    = 7'h24;
   localparam logic [6:0] OFF_IDLE_LVL   = 7'h25;
   localparam logic [6:0] OFF_DATA_LO    = 7'h26;
   localparam logic [6:0] OFF_DATA_HI    = 7'h27;
   localparam logic [6:0] OFF_STATUS     = 7'h28;
   // field positions
   localparam int PF_XFER_BIT   = 3;
   localparam int PF_DIR_BIT    = 2;
   localparam int PF_ENA_BIT    = 1;
   localparam int IDLE_LVL_BIT  = 1;
   localparam int CS_DIV4_BIT   = 3;
   localparam int ST_FLAG_BIT   = 0;
   // reset values
   localparam logic [3:0] RST_PIN_FUNC = 4'h0;
   localparam logic [3:0] RST_CLK_SEL  = 4'h0;
   localparam logic [1:0] RST_IDLE_LVL = 2'h0;
   // timing
   localparam int CLK_SEL_DELAY = 2;  // instructions until a clock select acts
   localparam int BITS_PER_XFER = 8;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CSEL_SYSCLK = 3'h6;
   localparam logic [2:0] CSEL_EXT    = 3'h7;
   typedef enum logic [1:0] {
      ST_START_WAIT = 2'b00,
      ST_CLK_WAIT   = 2'b01,
      ST_XFER       = 2'b10,
      ST_CONT       = 2'b11
   } cssp_state_t;
endpackage

// ==== tb/cssp_assertions.sv ====
module cssp_assertions (
   input wire logic       mclk,       // system clock
   input wire logic       rst,        // sync reset
   input wire logic [6:0] reg_addr,   // address
   input wire logic [3:0] reg_wdata,  // write nibble
   input wire logic       reg_wr,     // write strobe
   input wire logic       reg_rd,     // read strobe
   input wire logic [3:0] reg_rdata,  // read data
   input wire logic       start_xfer, // start pulse
   input wire logic       flag_clr,   // flag clear
   input wire logic       req_flag,   // request flag
   input wire logic       sck_out,    // clock level
   input wire logic       sck_oe_n    // clock pin enable
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence s_csel;
      reg_wr && reg_addr == cssp_pkg::OFF_CLK_SEL;
   endsequence
   sequence s_stat;
      reg_rd && reg_addr == cssp_pkg::OFF_STATUS;
   endsequence
   chk_rd_quiet: assert property (
      !$past(reg_rd) |-> reg_rdata == 4'h0)
      else $error("read data outside read slot");
   chk_unmapped_rd: assert property (
      reg_rd && reg_addr == 7'h30 |=> reg_rdata == 4'h0)
      else $error("unmapped read not zero");
   chk_stat_flag: assert property (
      s_stat |=> reg_rdata[cssp_pkg::ST_FLAG_BIT] == $past(req_flag))
      else $error("status flag bit wrong");
   chk_flag_hold: assert property (
      req_flag && !flag_clr |=> req_flag)
      else $error("flag dropped without clear");
   chk_flag_rst: assert property (
      $fell(rst) |-> !req_flag && sck_out)
      else $error("flag or clock wrong after reset");
   // sampled after the select has acted; the clock must then sit high for two cycles
   chk_csel_halt: assert property (
      s_csel |-> ##4 sck_out [*2])
      else $error("clock runs after clock select write");
   chk_flag_stop: assert property (
      $rose(req_flag) && !sck_oe_n && !$past(start_xfer || reg_wr)
      && !$past(start_xfer || reg_wr, 2) |-> sck_out [*2])
      else $error("internal clock not stopped high");
   chk_ext_oe: assert property (
      s_csel ##0 reg_wdata[2:0] == cssp_pkg::CSEL_EXT |-> ##4 sck_oe_n)
      else $error("clock pin driven in external mode");
endmodule

bind cssp_top cssp_assertions u_cssp_assertions (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .start_xfer(start_xfer), .flag_clr(flag_clr), .req_flag(req_flag),
   .sck_out(sck_out), .sck_oe_n(sck_oe_n));

// ==== tb/cssp_peer.sv ====
module cssp_peer (
   input  wire logic       mclk,     // system clock
   input  wire logic       sck_out,  // clock from the block
   input  wire logic       sck_oe_n, // low while block drives clock
   input  wire logic       sdo,      // data from the block
   input  wire logic [7:0] tx,       // byte to send
   input  wire logic [3:0] npulse,   // pulses per frame, above 8 is noise
   input  wire logic       go,       // frame request
   output logic            sck_in,   // our clock, idles high
   output logic            sdi,      // our data
   output logic      [7:0] rx        // byte received
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic sck;
   int        bi;
   assign sck = sck_oe_n ? sck_in : sck_out;
   initial begin
      sck_in = 1'b1;
      sdi = 1'b0;
      rx = 8'h00;
      bi = 0;
   end
   // four cycles a phase so the three-cycle synchroniser sees each level
   always @(posedge go) begin
      bi = 0;
      repeat (npulse) begin
         repeat (4) @(posedge mclk);
         sck_in <= 1'b0;
         repeat (4) @(posedge mclk);
         sck_in <= 1'b1;
      end
   end
   always @(negedge sck) sdi <= tx[bi[2:0]];
   always @(posedge sck) begin
      rx <= {sdo, rx[7:1]};
      bi = bi + 1;
      // released after the last bit, but only once the three-cycle
      // synchroniser has let the block sample it
      if (bi[2:0] == 3'h0) begin
         repeat (3) @(posedge mclk);
         sdi <= ~sdi;
      end
   end
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] A_PF = cssp_pkg::OFF_PIN_FUNC;
   localparam logic [6:0] A_CS = cssp_pkg::OFF_CLK_SEL;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic [6:0] reg_addr = 7'h00;
   logic [3:0] reg_wdata = 4'h0;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       start_xfer = 1'b0;
   logic       flag_clr = 1'b0;
   logic       go = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [3:0] npulse = 4'h0;
   logic [3:0] reg_rdata, d, cs[2] = '{4'h5, 4'hD};
   logic [7:0] rx, per[2] = '{8'h04, 8'h08};
   logic       req_flag, sck_in, sck_out, sck_oe_n, sdi, sdo, sdo_oe_n;
   int         n_errors = 0;
   int         checks = 0;
   int         nfall = 0;
   time        t0, t1;
   always #20 mclk = ~mclk;
   always @(negedge sck_out) begin
      t0 = t1;
      t1 = $time;
      nfall++;
   end
   cssp_top u_cssp_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .start_xfer(start_xfer), .flag_clr(flag_clr),
      .req_flag(req_flag), .sck_in(sck_in), .sck_out(sck_out),
      .sck_oe_n(sck_oe_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
   cssp_peer u_cssp_peer (.mclk(mclk), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .sdo(sdo), .tx(tx), .npulse(npulse), .go(go), .sck_in(sck_in),
      .sdi(sdi), .rx(rx));
   task automatic chk(input string n, input logic [7:0] s, x);
      checks++;
      if (s !== x) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [3:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [3:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic pulse(input bit s);
      if (s) start_xfer <= 1'b1;
      else flag_clr <= 1'b1;
      @(posedge mclk);
      start_xfer <= 1'b0;
      flag_clr <= 1'b0;
   endtask
   task automatic st(input logic [1:0] x);
      rd(cssp_pkg::OFF_STATUS, d);
      chk("state", 8'(d[3:2]), 8'(x));
   endtask
   // waits past the two-cycle select delay before any start; the select
   // write in start-wait raises the flag, so it is cleared here
   task automatic setup(input logic [3:0] pf, c);
      wr(A_PF, pf);
      wr(A_CS, c);
      repeat (4) @(posedge mclk);
      pulse(1'b0);
   endtask
   task automatic xfer(input logic [3:0] pf, c, input logic [7:0] t,
                       input logic [3:0] n);
      setup(pf, c);
      tx <= t;
      npulse <= n;
      nfall = 0;
      go <= 1'b1;
      pulse(1'b1);
      go <= 1'b0;
      for (int i = 0; i < 3000 && req_flag !== 1'b1; i++) @(posedge mclk);
      chk("req_flag", 8'(req_flag), 8'h01);
   endtask
   initial begin
      #800000;
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("flag", 8'(req_flag), 8'h00);
      st(2'b00);
      rd(7'h30, d);
      chk("unmapped", 8'(d), 8'h00);
      $display("test reset done");
      wr(cssp_pkg::OFF_DATA_LO, 4'h5);
      wr(cssp_pkg::OFF_DATA_HI, 4'hA);
      xfer(4'hE, cssp_pkg::CSEL_SYSCLK, 8'h3C, 4'h0);
      chk("peer_rx", rx, 8'hA5);
      chk("falls", 8'(nfall), 8'h08);
      chk("oe", 8'({sck_oe_n, sdo_oe_n}), 8'h00);
      rd(cssp_pkg::OFF_DATA_LO, d);
      chk("data_lo", 8'(d), 8'h05);
      rd(cssp_pkg::OFF_DATA_HI, d);
      chk("data_hi", 8'(d), 8'h0A);
      st(2'b00);
      pulse(1'b0);
      foreach (cs[i]) begin
         xfer(4'hE, cs[i], 8'h00, 4'h0);
         chk("period", 8'((t1 - t0) / 40), per[i]);
         pulse(1'b0);
      end
      $display("test internal done");
      xfer(4'hA, cssp_pkg::CSEL_EXT, 8'h96, 4'h8);
      rd(cssp_pkg::OFF_DATA_LO, d);
      chk("rx_lo", 8'(d), 8'h06);
      rd(cssp_pkg::OFF_DATA_HI, d);
      chk("rx_hi", 8'(d), 8'h09);
      chk("oe", 8'({sck_oe_n, sdo_oe_n}), 8'h03);
      st(2'b01);
      pulse(1'b0);
      xfer(4'hA, cssp_pkg::CSEL_EXT, 8'h00, 4'h9);
      repeat (12) @(posedge mclk);
      st(2'b10);
      pulse(1'b0);
      wr(A_CS, cssp_pkg::CSEL_EXT);
      repeat (4) @(posedge mclk);
      chk("flag", 8'(req_flag), 8'h01);
      st(2'b00);
      pulse(1'b0);
      $display("test external done");
      setup(4'hE, 4'hD);
      pulse(1'b1);
      repeat (24) @(posedge mclk);
      pulse(1'b1);
      repeat (2) @(posedge mclk);
      chk("abort_flag", 8'(req_flag), 8'h01);
      wr(A_CS, 4'hD);
      repeat (6) @(posedge mclk);
      st(2'b00);
      setup(4'h2, cssp_pkg::CSEL_SYSCLK);
      pulse(1'b1);
      repeat (6) @(posedge mclk);
      st(2'b11);
      wr(A_CS, cssp_pkg::CSEL_SYSCLK);
      repeat (6) @(posedge mclk);
      st(2'b00);
      wr(cssp_pkg::OFF_IDLE_LVL, 4'h2);
      repeat (2) @(posedge mclk);
      chk("idle_hi", 8'(sdo), 8'h01);
      wr(cssp_pkg::OFF_IDLE_LVL, 4'h0);
      repeat (2) @(posedge mclk);
      chk("idle_lo", 8'(sdo), 8'h00);
      $display("test control done");
      end_sim();
   end
endmodule
